// File: bgr_pkg.sv
package bgr_pkg;

  // ----------------------------------------------------------------
  // Register file geometry
  // ----------------------------------------------------------------
  localparam int GR_W       = 64;
  localparam int NPHYS      = 144;
  localparam logic [6:0] BANK_LO = 7'h10;
  localparam logic [6:0] BANK_HI = 7'h1f;
  localparam logic [7:0] BANK0_BASE = 8'h80;
  localparam logic [6:0] SCR_LO  = 7'h18;
  localparam logic [6:0] KEEP_HI = 7'h17;

  // ----------------------------------------------------------------
  // Bus register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam int CTRL_BN   = 0;
  localparam int CTRL_SBN  = 1;
  localparam int CTRL_IC   = 2;
  localparam int CTRL_IE   = 3;
  localparam int STAT_BN   = 0;
  localparam int STAT_FWD  = 1;
  localparam int STAT_LDIDX = 8;
  localparam logic RST_BN  = 1'b0;
  localparam logic RST_SBN = 1'b0;
  localparam logic RST_IC  = 1'b0;
  localparam logic RST_IE  = 1'b0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic            en;
    logic [6:0]      idx;
  } bgr_rd_t;

  typedef struct packed {
    logic [GR_W-1:0] data;
    logic            dtag;
  } bgr_val_t;

  typedef struct packed {
    logic            we;
    logic [6:0]      idx;
    bgr_val_t        val;
  } bgr_wr_t;

  typedef struct packed {
    logic            we;
    logic [2:0]      sel;
    bgr_val_t        val;
  } bgr_fw_t;

  typedef struct packed {
    logic            intr;
    logic            rfi;
    logic            bsw;
    logic            bsw_bank;
  } bgr_evt_t;

  typedef struct packed {
    logic            valid;
    logic [6:0]      idx;
  } bgr_ldtrk_t;

  typedef struct packed {
    logic            bank;
    logic            saved_bank;
    logic            ic;
    logic            ie;
    logic            fw_dirty;
    logic            dph_wr;
    logic [7:0]      dph_addr;
    logic [31:0]     hrdata;
    bgr_val_t        rd_val;
    bgr_ldtrk_t      ldtrk;
  } bgr_state_t;

endpackage

// File: bgr_regfile.sv
`timescale 1ns/1ns
// What this block does
// - Interruption forces banked registers to bank 0
// - Indices 16-31 use bank chosen by select bit
// - Return from interruption restores saved bank
// - Bank switch selects the named bank
// - Earlier accesses finish on the old bank
// - Banks keep data and tag across switches
// - Only selected bank is addressable by the pipeline ports
// - Unbanked registers ignore the bank select
// - Load table sees one register per index
// - Firmware may clobber bank 0 24-31 when collecting
// - Registers 16-23 are never disturbed
module bgr_regfile
  import bgr_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Pipeline register ports
  input  wire bgr_rd_t     gr_rd,
  output bgr_val_t         gr_rdata,
  input  wire bgr_wr_t     gr_wr,
  // Interruption and bank events
  input  wire bgr_evt_t    evt,
  // Firmware scratch write
  input  wire bgr_fw_t     fw_wr,
  // Status bits and load table tracking
  output logic             bank_select_bit,
  output logic             saved_bank_select_bit,
  output logic             collection_enable_bit,
  output logic             interrupt_enable_bit,
  output bgr_ldtrk_t       ld_kill
);

  default clocking core_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------
  // Index mapping
  // ----------------------------------------------------------------
  // Bank 1 lives at the architectural slots, bank 0 above 127
  function automatic logic [7:0] phys(input logic [6:0] idx,
                                      input logic       bank);
    logic [7:0] p;
    p = {1'b0, idx};
    if (idx >= BANK_LO && idx <= BANK_HI && !bank) begin
      p = BANK0_BASE + {4'h0, idx[3:0]};
    end
    return p;
  endfunction

  bgr_val_t   gr_mem [NPHYS];
  bgr_state_t st;
  bgr_state_t next_st;
  logic [7:0] wr_phys;
  logic [7:0] rd_phys;
  logic [7:0] fw_phys;
  logic       fw_hit;
  logic       ahb_take;
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;

  // ----------------------------------------------------------------
  // Physical addressing
  // ----------------------------------------------------------------
  // Select bank path
  // one bank mapping
  assign rd_phys = phys(gr_rd.idx, st.bank);
  // Prior bank path
  // old bank used
  assign wr_phys = phys(gr_wr.idx, st.bank);
  assign fw_phys = BANK0_BASE + {5'h01, fw_wr.sel};
  // Firmware scratch gate
  // only 24-31
  assign fw_hit  = fw_wr.we && st.ic;

  assign ahb_take = hsel && htrans[1] && hready;

  assign ctrl_word = {28'h0, st.ie, st.ic, st.saved_bank, st.bank};
  assign stat_word = {17'h0, st.ldtrk.idx, 6'h0, st.fw_dirty, st.bank};

  // ----------------------------------------------------------------
  // Register array
  // ----------------------------------------------------------------
  // Tag stored with data
  // tag kept
  always_ff @(posedge hclk) begin
    if (fw_hit) begin
      gr_mem[fw_phys] <= fw_wr.val;
    end
    // Pipeline write wins a same-slot collision with firmware
    if (gr_wr.we) begin
      gr_mem[wr_phys] <= gr_wr.val;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // Index holds for the status word; only the strobe drops
    next_st.ldtrk.valid = 1'b0;
    if (gr_rd.en) begin
      next_st.rd_val = gr_mem[rd_phys];
    end
    // Load table tracking drops the bank
    // bank-blind index
    if (gr_wr.we) begin
      next_st.ldtrk = '{valid: 1'b1, idx: gr_wr.idx};
    end
    if (fw_hit) begin
      next_st.fw_dirty = 1'b1;
    end
    // Bus data phase; a pending write lands first
    if (st.dph_wr) begin
      if (st.dph_addr == OFS_CTRL) begin
        next_st.bank       = hwdata[CTRL_BN];
        next_st.saved_bank = hwdata[CTRL_SBN];
        next_st.ic         = hwdata[CTRL_IC];
        next_st.ie         = hwdata[CTRL_IE];
      end
      // Clear by writing one; a same-cycle firmware hit keeps it set
      if (st.dph_addr == OFS_STAT && hwdata[STAT_FWD] && !fw_hit) begin
        next_st.fw_dirty = 1'b0;
      end
    end
    // Events beat software writes; interruption beats all
    // switch to target
    if (evt.bsw) begin
      next_st.bank = evt.bsw_bank;
    end
    if (evt.rfi) begin
      next_st.bank = st.saved_bank;
    end
    // Interruption saves the old bank and clears collection
    // force bank 0
    if (evt.intr) begin
      next_st.saved_bank = st.bank;
      next_st.bank       = 1'b0;
      next_st.ic         = 1'b0;
    end
    next_st.dph_wr   = ahb_take && hwrite;
    next_st.dph_addr = haddr[7:0];
    if (ahb_take && !hwrite) begin
      unique case (haddr[7:0])
        OFS_CTRL: next_st.hrdata = ctrl_word;
        OFS_STAT: next_st.hrdata = stat_word;
        default:  next_st.hrdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '{bank: RST_BN, saved_bank: RST_SBN, ic: RST_IC,
              ie: RST_IE, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Zero wait state slave, always OKAY
  assign hreadyout             = 1'b1;
  assign hresp                 = 1'b0;
  assign hrdata                = st.hrdata;
  assign gr_rdata              = st.rd_val;
  assign bank_select_bit       = st.bank;
  assign saved_bank_select_bit = st.saved_bank;
  assign collection_enable_bit = st.ic;
  assign interrupt_enable_bit  = st.ie;
  assign ld_kill               = st.ldtrk;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic bank_chg;
  assign bank_chg = next_st.bank != st.bank;

  // Interruption lands on bank 0
  // bank zero
  chk_intr_bank0: assert property (
    evt.intr |=> !bank_select_bit && saved_bank_select_bit == $past(st.bank))
    else $error("interruption did not select bank 0");

  // Return restores saved bank
  // saved bank
  chk_rfi_restore: assert property (
    evt.rfi && !evt.intr |=> bank_select_bit == $past(st.saved_bank))
    else $error("return did not restore saved bank");

  // Switch reaches named bank
  // target bank
  chk_bsw_target: assert property (
    evt.bsw && !evt.rfi && !evt.intr |=>
      bank_select_bit == $past(evt.bsw_bank))
    else $error("bank switch missed its target");

  // Write in switch cycle uses old bank
  // prior bank
  chk_old_bank_wr: assert property (
    gr_wr.we && gr_wr.idx >= BANK_LO && gr_wr.idx <= BANK_HI |->
      (wr_phys < BANK0_BASE) == st.bank)
    else $error("banked write used the wrong bank");

  // Written value and tag come back
  // data and tag
  chk_wr_rd_data: assert property (
    gr_wr.we && !bank_chg && !(fw_hit && fw_phys == wr_phys) ##1
      (gr_rd.en && gr_rd.idx == $past(gr_wr.idx)) |=>
      gr_rdata == $past(gr_wr.val, 2))
    else $error("read back differs from write");

  // Unbanked slots ignore bank
  // unbanked direct
  chk_unbanked: assert property (
    gr_rd.en && (gr_rd.idx < BANK_LO || gr_rd.idx > BANK_HI) |->
      rd_phys == {1'b0, gr_rd.idx})
    else $error("unbanked register was remapped");

  // Load table index is bank blind
  // same index
  chk_ldtrk_index: assert property (
    gr_wr.we |=> ld_kill.valid && ld_kill.idx == $past(gr_wr.idx))
    else $error("load table index wrong");

  // A refused firmware write leaves its slot untouched
  // collection gate
  chk_fw_gate: assert property (
    fw_wr.we && !collection_enable_bit &&
      !(gr_wr.we && wr_phys == fw_phys) |=>
      gr_mem[$past(fw_phys)] == $past(gr_mem[fw_phys]))
    else $error("firmware wrote while not collecting");

  // Firmware never reaches 16-23
  // low half kept
  chk_low_kept: assert property (
    fw_hit |-> fw_phys >= BANK0_BASE + {1'b0, SCR_LO - BANK_LO} &&
      fw_phys < BANK0_BASE + 8'h10 && fw_phys != {1'b0, KEEP_HI})
    else $error("firmware touched a preserved register");

  // Bus read reflects control
  chk_bus_read: assert property (
    ahb_take && !hwrite && haddr[7:0] == OFS_CTRL |=>
      hrdata[CTRL_BN] == $past(st.bank))
    else $error("control read mismatch");

  cov_intr_rfi: cover property (@(posedge hclk) disable iff (!hresetn)
    evt.intr ##[1:20] evt.rfi);
  cov_bsw_one: cover property (@(posedge hclk) disable iff (!hresetn)
    evt.bsw && evt.bsw_bank && gr_wr.we);
  cov_fw_write: cover property (@(posedge hclk) disable iff (!hresetn)
    fw_hit);
  cov_bus_write: cover property (@(posedge hclk) disable iff (!hresetn)
    st.dph_wr && st.dph_addr == OFS_CTRL);

endmodule // bgr_regfile

// File: bgr_pipe_model.sv
`timescale 1ns/1ns
module bgr_pipe_model
  import bgr_pkg::*;
(
  // Clock and core status
  input  wire logic hclk,
  input  wire logic bank,
  input  wire logic ic,
  // Requests to the register file
  output bgr_rd_t   gr_rd,
  output bgr_wr_t   gr_wr,
  output bgr_evt_t  evt,
  output bgr_fw_t   fw_wr
);
  initial begin
    gr_rd = '0;
    gr_wr = '0;
    evt   = '0;
    fw_wr = '0;
  end

  // One request cycle; released fields carry junk, not the old value
  task automatic step(input bgr_rd_t r, input bgr_wr_t w,
                      input bgr_evt_t e, input bgr_fw_t f);
    @(posedge hclk);
    // scratch use only when not collecting
    if (w.we && !bank && ic && w.idx >= SCR_LO && w.idx <= BANK_HI)
      w.we = 1'b0;
    gr_rd <= r;
    gr_wr <= w;
    evt   <= e;
    fw_wr <= f;
    @(posedge hclk);
    gr_rd <= {1'b0, ~r.idx};
    gr_wr <= {1'b0, ~w.idx, ~w.val};
    evt   <= '0;
    fw_wr <= {1'b0, ~f.sel, ~f.val};
  endtask

  // Write then read of one index on adjacent edges
  task automatic wr_rd(input bgr_wr_t w);
    @(posedge hclk);
    gr_wr <= w;
    @(posedge hclk);
    gr_wr <= {1'b0, ~w.idx, ~w.val};
    gr_rd <= {1'b1, w.idx};
    @(posedge hclk);
    gr_rd <= {1'b0, ~w.idx};
  endtask
endmodule // bgr_pipe_model

// File: banked_general_registers_tb_top.sv
`timescale 1ns/1ns
module banked_general_registers_tb_top import bgr_pkg::*;;
  localparam int FWB = int'(BANK0_BASE) + 8;
  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic        bank_select_bit, saved_bank_select_bit;
  logic        collection_enable_bit, interrupt_enable_bit;
  bgr_rd_t     gr_rd;
  bgr_wr_t     gr_wr;
  bgr_evt_t    evt;
  bgr_fw_t     fw_wr;
  bgr_val_t    gr_rdata;
  bgr_ldtrk_t  ld_kill;
  bgr_val_t    mem [0:143];
  bgr_wr_t     wb;
  logic        bk = 0, sv = 0, ic = 0, ie = 0, fd = 0;
  logic [6:0]  lw = 7'h00;
  logic [31:0] seed = 32'h6302870f;
  int          fails = 0, total_checks = 0, cyc = 0;
  int          ix [6] = '{5, 16, 23, 24, 31, 40};

  always #4 hclk = ~hclk;
  assign hready = hreadyout;

  bgr_regfile i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .gr_rd,
    .gr_rdata, .gr_wr, .evt, .fw_wr, .bank_select_bit,
    .saved_bank_select_bit, .collection_enable_bit,
    .interrupt_enable_bit, .ld_kill);
  bgr_pipe_model i_pipe (.hclk, .bank(bank_select_bit),
    .ic(collection_enable_bit), .gr_rd, .gr_wr, .evt, .fw_wr);

  // ----------------------------------------
  // Reference model and helpers
  // ----------------------------------------
  function automatic bgr_val_t rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return {seed, ~seed, seed[5]};
  endfunction

  function automatic int ph(input logic [6:0] i);
    if (!bk && i >= BANK_LO && i <= BANK_HI)
      return int'(BANK0_BASE) - int'(BANK_LO) + int'(i);
    return int'(i);
  endfunction

  task automatic chk(input logic [64:0] g, input logic [64:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Old bank serves every access of the event cycle
  task automatic op(input bgr_rd_t r, input bgr_wr_t w,
                    input bgr_evt_t e, input bgr_fw_t f);
    bgr_val_t x;
    x = mem[ph(r.idx)];
    i_pipe.step(r, w, e, f);
    // Pipeline write lands after firmware so it wins a shared slot
    if (f.we && ic) begin
      mem[FWB + int'(f.sel)] = f.val;
      fd = 1'b1;
    end
    if (w.we) begin
      mem[ph(w.idx)] = w.val;
      lw = w.idx;
    end
    if (e.intr) begin
      sv = bk;
      bk = 1'b0;
      ic = 1'b0;
    end else if (e.rfi)
      bk = sv;
    else if (e.bsw)
      bk = e.bsw_bank;
    #1;
    if (r.en)
      chk(gr_rdata, x);
    if (w.we)
      chk(ld_kill, {1'b1, w.idx});
    chk({bank_select_bit, saved_bank_select_bit}, {bk, sv});
    chk(collection_enable_bit, ic);
    chk(interrupt_enable_bit, ie);
  endtask

  task automatic wrr(input int i);
    op('0, {1'b1, 7'(i), rnd()}, '0, '0);
  endtask

  task automatic rdd(input int i);
    op({1'b1, 7'(i)}, '0, '0, '0);
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    if (w && a == OFS_CTRL)
      {ie, ic, sv, bk} = d[3:0];
    if (w && a == OFS_STAT && d[STAT_FWD])
      fd = 1'b0;
  endtask

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chk({hreadyout, hresp, bank_select_bit}, 3'b100);
    for (int b = 0; b < 2; b++) begin
      ahb(1'b1, OFS_CTRL, 32'(b));
      foreach (ix[k]) wrr(ix[k]);
    end
    for (int b = 1; b >= 0; b--) begin
      op('0, '0, {3'b001, 1'(b)}, '0);
      foreach (ix[k]) rdd(ix[k]);
    end
    op({1'b1, 7'd16}, {1'b1, 7'd16, rnd()}, 4'b0011, '0);
    rdd(16);
    op('0, '0, 4'b0010, '0);
    rdd(16);
    wb = {1'b1, 7'd20, rnd()};
    i_pipe.wr_rd(wb);
    mem[ph(7'd20)] = wb.val;
    lw = 7'd20;
    #1;
    chk(gr_rdata, wb.val);
    ahb(1'b1, OFS_CTRL, 32'h5);
    op('0, '0, 4'b1000, '0);
    rdd(16);
    ahb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, {ie, ic, sv, bk});
    op('0, '0, 4'b0100, '0);
    rdd(31);
    ahb(1'b1, OFS_CTRL, 32'h4);
    for (int s = 0; s < 8; s++)
      op('0, '0, '0, {1'b1, 3'(s), rnd()});
    for (int i = 16; i < 32; i += 7) rdd(i);
    ahb(1'b0, OFS_STAT, 32'h0);
    chk(rd, {17'h0, lw, 6'h0, fd, bk});
    ahb(1'b1, OFS_STAT, 32'h2);
    ahb(1'b0, OFS_STAT, 32'h0);
    chk(rd, {17'h0, lw, 6'h0, fd, bk});
    ahb(1'b1, OFS_CTRL, 32'h8);
    op('0, '0, '0, {1'b1, 3'd1, rnd()});
    rdd(25);
    ahb(1'b1, 8'h08, 32'hf);
    ahb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, {ie, ic, sv, bk});
    end_of_test();
  end
endmodule // banked_general_registers_tb_top
